// file: logic/arm_ctl_pkg.sv
package arm_ctl_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_LINES = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_DONE_CNT = 8'h10;
  // control field positions
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_BYPASS_BIT = 4;
  localparam int CTRL_START_BIT = 8;
  localparam int CTRL_ABORT_BIT = 9;
  // line select field positions
  localparam int LINES_IN_LSB = 0;
  localparam int LINES_OUT_LSB = 4;
  // status field positions
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_REJECT_BIT = 4;
  localparam int STAT_BYPUSED_BIT = 5;
  // arming event codes
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_IMMEDIATE = 3'h1;
  localparam logic [2:0] SRC_BUS = 3'h2;
  localparam logic [2:0] SRC_EXTERNAL = 3'h3;
  localparam logic [2:0] SRC_MULTI = 3'h4;
  localparam logic [2:0] SRC_HOLD = 3'h5;
  localparam logic [2:0] SRC_TIMER = 3'h6;
  // trigger bus and count limits
  localparam int TBUS_LINES = 6;
  localparam logic [13:0] COUNT_MAX = 14'h270F;
  localparam logic [13:0] COUNT_INFINITE = 14'h0000;
  // reset values
  localparam logic [2:0] RST_SRC = SRC_IMMEDIATE;
  localparam logic [13:0] RST_COUNT = 14'h0001;
  localparam logic [2:0] RST_IN_LINE = 3'h1;
  localparam logic [2:0] RST_OUT_LINE = 3'h2;
  // arm layer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_SCAN
  } arm_state_t;
endpackage

// file: logic/arm_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
// event strobes from the edge detectors into the arm sequencer
interface arm_evt_if;
  logic step;
  logic bus;
  logic ext;
  logic [5:0] tbus;
  modport src (output step, output bus, output ext, output tbus);
  modport dst (input step, input bus, input ext, input tbus);
endinterface
`default_nettype wire

// file: logic/rise_det.sv
`timescale 1ns/10ps
`default_nettype none
// rising edge detector, one-cycle pulse per edge
module rise_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic pulse
);
  logic prev_ff;
  logic nxt_prev;

  // hold the previous level so a long press counts once
  always_comb begin
    nxt_prev = din;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  assign pulse = din & ~prev_ff;
endmodule
`default_nettype wire

// file: logic/arm_layer_ctl.sv
// Implementation choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - manual selected: only step key arms
// - step key active under timer/ext/bus/multi
// - step key advances under bus/ext/multi
// - immediate passes into scan at once
// - bus trigger arms when bus selected
// - external trigger arms when external selected
// - multi-line bus pulse arms when selected
// - input line selectable one through six
// - separate output line, equal lines rejected
// - hold never advances into scan
// - count sets passes, zero means infinite
// - finite count one to 9999
// - all zeros encodes infinite
// - count one arms exactly once
// - bypass skips first wait for ext/multi
// - acceptor setting disables bypass
module arm_layer_ctl
  import arm_ctl_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic STEP_KEY,
  input wire logic BUS_TRIG,
  input wire logic EXT_TRIG,
  input wire logic TIMER_TICK,
  input wire logic [5:0] TBUS_IN,
  input wire logic SCAN_DONE,
  output logic SCAN_GO,
  output logic [5:0] TBUS_OUT,
  output logic [5:0] TBUS_OE
);
  arm_evt_if evt ();

  // edge detectors for the step key, bus, external and trigger bus inputs; timer tick used as is
  rise_det u_step (.clk(CLK), .rst(RST), .din(STEP_KEY), .pulse(evt.step));
  rise_det u_bus (.clk(CLK), .rst(RST), .din(BUS_TRIG), .pulse(evt.bus));
  rise_det u_ext (.clk(CLK), .rst(RST), .din(EXT_TRIG), .pulse(evt.ext));
  genvar gi;
  generate
    for (gi = 0; gi < TBUS_LINES; gi++) begin : g_tb
      rise_det u_tb (.clk(CLK), .rst(RST), .din(TBUS_IN[gi]), .pulse(evt.tbus[gi]));
    end
  endgenerate

  logic [2:0] src_ff, nxt_src;
  logic bypass_ff, nxt_bypass;
  logic [13:0] count_ff, nxt_count;
  logic [2:0] in_line_ff, nxt_in_line;
  logic [2:0] out_line_ff, nxt_out_line;
  logic reject_ff, nxt_reject;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic start_req, abort_req;
  arm_state_t state_ff, nxt_state;
  logic [13:0] done_ff, nxt_done;
  logic byp_used_ff, nxt_byp_used;
  logic go_ff, nxt_go;
  logic [5:0] tout_ff, nxt_tout;
  logic [5:0] toe_ff, nxt_toe;
  logic arm_event;
  logic [2:0] w_in, w_out;
  logic [13:0] w_cnt;
  logic wr_acc;

  assign wr_acc = PSEL & PENABLE & PWRITE & ~pready_ff;
  assign w_in = PWDATA[LINES_IN_LSB +: 3];
  assign w_out = PWDATA[LINES_OUT_LSB +: 3];
  assign w_cnt = PWDATA[13:0];

  // apb slave: one wait state, so every access answers on the second access edge
  always_comb begin
    nxt_src = src_ff;
    nxt_bypass = bypass_ff;
    nxt_count = count_ff;
    nxt_in_line = in_line_ff;
    nxt_out_line = out_line_ff;
    nxt_reject = reject_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = PSEL & PENABLE & ~pready_ff;
    start_req = 1'b0;
    abort_req = 1'b0;
    if (wr_acc) begin
      case (PADDR)
        OFS_CTRL: begin
          if (PWDATA[CTRL_SRC_LSB +: 3] <= SRC_TIMER) begin
            nxt_src = PWDATA[CTRL_SRC_LSB +: 3];
          end else begin
            nxt_pslverr = 1'b1;
          end
          nxt_bypass = PWDATA[CTRL_BYPASS_BIT]; // acceptor when clear
          start_req = PWDATA[CTRL_START_BIT];
          abort_req = PWDATA[CTRL_ABORT_BIT];
        end
        OFS_COUNT: begin
          if (w_cnt <= COUNT_MAX) begin // zero kept as infinite
            nxt_count = w_cnt;
          end else begin
            nxt_pslverr = 1'b1;
          end
        end
        OFS_LINES: begin
          // lines are one-based; equal or out-of-range pairs are refused
          if (w_in == 3'h0 || w_in > 3'h6 || w_out == 3'h0 || w_out > 3'h6 || w_in == w_out) begin
            nxt_reject = 1'b1;
            nxt_pslverr = 1'b1;
          end else begin
            nxt_reject = 1'b0;
            nxt_in_line = w_in;
            nxt_out_line = w_out;
          end
        end
        default: nxt_pslverr = 1'b1;
      endcase
    end else if (PSEL & PENABLE & ~pready_ff) begin
      case (PADDR)
        OFS_CTRL: nxt_prdata = {27'h0, bypass_ff, 1'b0, src_ff};
        OFS_COUNT: nxt_prdata = {18'h0, count_ff};
        OFS_LINES: nxt_prdata = {25'h0, out_line_ff, 1'b0, in_line_ff};
        OFS_STATUS: nxt_prdata = {26'h0, byp_used_ff, reject_ff, 2'h0, state_ff};
        OFS_DONE_CNT: nxt_prdata = {18'h0, done_ff};
        default: begin
          nxt_prdata = 32'h0;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      src_ff <= RST_SRC;
      bypass_ff <= 1'b0;
      count_ff <= RST_COUNT;
      in_line_ff <= RST_IN_LINE;
      out_line_ff <= RST_OUT_LINE;
      reject_ff <= 1'b0;
      prdata_ff <= 32'h0;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      src_ff <= nxt_src;
      bypass_ff <= nxt_bypass;
      count_ff <= nxt_count;
      in_line_ff <= nxt_in_line;
      out_line_ff <= nxt_out_line;
      reject_ff <= nxt_reject;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // arming event select; step key works in every waiting source except hold/immediate
  always_comb begin
    case (src_ff)
      SRC_MANUAL: arm_event = evt.step;
      SRC_IMMEDIATE: arm_event = 1'b1;
      SRC_BUS: arm_event = evt.bus | evt.step;
      SRC_EXTERNAL: arm_event = evt.ext | evt.step;
      SRC_MULTI: arm_event = evt.tbus[in_line_ff - 3'h1] | evt.step;
      SRC_TIMER: arm_event = TIMER_TICK | evt.step;
      SRC_HOLD: arm_event = 1'b0;
      default: arm_event = 1'b0;
    endcase
  end

  // arm sequencer: arm layer waits, scan layer runs until scan reports done
  always_comb begin
    nxt_state = state_ff;
    nxt_done = done_ff;
    nxt_byp_used = byp_used_ff;
    nxt_go = 1'b0;
    nxt_tout = 6'h0;
    nxt_toe = 6'h0;
    nxt_toe[out_line_ff - 3'h1] = 1'b1; // selected output line driven
    case (state_ff)
      ST_IDLE: begin
        if (start_req) begin
          nxt_state = ST_ARM;
          nxt_done = 14'h0;
          nxt_byp_used = 1'b0;
        end
      end
      ST_ARM: begin
        if (abort_req) begin
          nxt_state = ST_IDLE;
        end else if (src_ff != SRC_HOLD && bypass_ff && !byp_used_ff &&
                     (src_ff == SRC_EXTERNAL || src_ff == SRC_MULTI)) begin
          nxt_byp_used = 1'b1; // first pass only
          nxt_state = ST_SCAN;
          nxt_go = 1'b1;
        end else if (arm_event) begin
          nxt_byp_used = 1'b1;
          nxt_state = ST_SCAN;
          nxt_go = 1'b1;
          nxt_tout[out_line_ff - 3'h1] = 1'b1; // announce arming on output line
        end
      end
      ST_SCAN: begin
        if (abort_req) begin
          nxt_state = ST_IDLE;
        end else if (SCAN_DONE) begin
          // saturate so an infinite run never wraps
          if (done_ff != COUNT_MAX) begin
            nxt_done = done_ff + 14'h1;
          end
          if (count_ff != COUNT_INFINITE && done_ff + 14'h1 >= count_ff) begin
            nxt_state = ST_IDLE; // count one ends after one pass
          end else begin
            nxt_state = ST_ARM;
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_ff <= ST_ARM;
      done_ff <= 14'h0;
      byp_used_ff <= 1'b0;
      go_ff <= 1'b0;
      tout_ff <= 6'h0;
      toe_ff <= 6'h0;
    end else begin
      state_ff <= nxt_state;
      done_ff <= nxt_done;
      byp_used_ff <= nxt_byp_used;
      go_ff <= nxt_go;
      tout_ff <= nxt_tout;
      toe_ff <= nxt_toe;
    end
  end

  assign PRDATA = prdata_ff;
  assign PREADY = pready_ff;
  assign PSLVERR = pslverr_ff;
  assign SCAN_GO = go_ff;
  assign TBUS_OUT = tout_ff;
  assign TBUS_OE = toe_ff;
endmodule
`default_nettype wire

// file: dv/arm_ctl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module arm_ctl_checker (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SCAN_GO,
  input wire logic [5:0] TBUS_OUT,
  input wire logic [5:0] TBUS_OE
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // apb answer comes after exactly one wait state
  property p_ready_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("ready late");
  property p_rdy_act;
    PREADY |-> PSEL && PENABLE;
  endproperty
  a_rdy_act: assert property (p_rdy_act) else $error("ready outside access");
  property p_rdy_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("ready held");
  property p_err_rdy;
    PSLVERR |-> PREADY;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("error without ready");
  // the out line is never lost once reset is over
  property p_oe_onehot;
    !$past(RST) |-> $onehot(TBUS_OE);
  endproperty
  a_oe_onehot: assert property (p_oe_onehot) else $error("out enable");
  property p_tout_oe;
    |TBUS_OUT |-> TBUS_OUT == TBUS_OE;
  endproperty
  a_tout_oe: assert property (p_tout_oe) else $error("pulse off line");
  property p_tout_pulse;
    |TBUS_OUT |=> TBUS_OUT == 6'h00;
  endproperty
  a_tout_pulse: assert property (p_tout_pulse) else $error("pulse held");
  // a pass needs a scan done first, so hand-overs never crowd together
  property p_go_gap;
    SCAN_GO |=> !SCAN_GO [*2];
  endproperty
  a_go_gap: assert property (p_go_gap) else $error("go too close");
  c_go: cover property (SCAN_GO);
  c_err: cover property (PSLVERR);
  c_tout: cover property (|TBUS_OUT);
endmodule
`default_nettype wire

// file: dv/scan_model.sv
`timescale 1ns/10ps
`default_nettype none
module scan_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic slow,
  output logic done
);
  logic [3:0] cnt_ff;
  // one scan pass per go; slow passes keep the arm layer waiting longer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      done <= 1'b0;
    end else begin
      done <= (cnt_ff == 4'h1);
      if (go) cnt_ff <= slow ? 4'h8 : 4'h2;
      else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import arm_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] ev = 10'h000; // step, bus, ext, timer, then six bus lines
  logic slow = 1'b0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, go, sdone;
  logic [5:0] tout, toe;
  logic [5:0] tout_seen = 6'h00;
  int error_cnt = 0;
  int num_checks = 0;
  int go_cnt = 0;
  int cyc = 0;
  int base;
  // event sources under test and the ev bit that each one arms on
  logic [2:0] srcs [5] = '{SRC_MANUAL, SRC_BUS, SRC_EXTERNAL, SRC_MULTI, SRC_TIMER};
  int evb [5] = '{0, 1, 2, 6, 3};
  arm_layer_ctl DUT (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .STEP_KEY(ev[0]), .BUS_TRIG(ev[1]), .EXT_TRIG(ev[2]), .TIMER_TICK(ev[3]),
    .TBUS_IN(ev[9:4]), .SCAN_DONE(sdone), .SCAN_GO(go), .TBUS_OUT(tout), .TBUS_OE(toe));
  scan_model SCAN (.clk(clk), .rst(rst), .go(go), .slow(slow), .done(sdone));
  always #12.5 clk = ~clk;
  // pass counting and the hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (go === 1'b1) go_cnt <= go_cnt + 1;
    tout_seen <= tout_seen | tout;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held from setup until pready is seen high at a rising edge; answer taken there
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    chk({31'h0, pslverr}, {31'h0, e});
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next call never re-raises psel in this time step
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rdat & m, exp);
  endtask
  task automatic start(input logic [2:0] src, input logic byp);
    apb(1'b1, OFS_CTRL, 32'h100 | {27'h0, byp, 1'b0, src}, 1'b0);
  endtask
  task automatic fire(input int k);
    ev <= 10'h001 << k;
    @(posedge clk);
    ev <= 10'h000;
    repeat (14) @(posedge clk);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    chk(go_cnt, 1);
    rd(OFS_STATUS, 32'h3, 32'h0);
    rd(OFS_DONE_CNT, 32'h3FFF, 32'h1);
    rd(OFS_COUNT, 32'h3FFF, 32'h1);
    rd(OFS_LINES, 32'h77, 32'h21);
    apb(1'b1, OFS_CTRL, 32'h7, 1'b1);
    apb(1'b1, OFS_COUNT, 32'h2710, 1'b1);
    apb(1'b1, OFS_COUNT, 32'h270F, 1'b0);
    rd(OFS_COUNT, 32'h3FFF, 32'h270F);
    apb(1'b1, OFS_LINES, 32'h33, 1'b1);
    rd(OFS_STATUS, 32'h10, 32'h10);
    apb(1'b1, OFS_LINES, 32'h50, 1'b1);
    apb(1'b1, 8'h14, 32'h0, 1'b1);
    apb(1'b1, OFS_LINES, 32'h53, 1'b0);
    rd(OFS_LINES, 32'h77, 32'h53);
    chk(toe, 6'h10);
    apb(1'b1, OFS_COUNT, 32'h1, 1'b0);
    base = go_cnt;
    start(SRC_HOLD, 1'b0);
    fire(0);
    fire(2);
    chk(go_cnt - base, 0);
    // each event source: a foreign event is ignored, its own arms, the step key arms too
    for (int i = 0; i < 5; i++) begin
      base = go_cnt;
      start(srcs[i], 1'b0);
      fire(evb[i] == 1 ? 2 : 1);
      chk(go_cnt - base, 0);
      fire(evb[i]);
      chk(go_cnt - base, 1);
      if (i > 0) begin
        start(srcs[i], 1'b0);
        fire(0);
        chk(go_cnt - base, 2);
      end
    end
    // the pass right after reset announces on the reset output line two as well
    chk(tout_seen, 6'h12);
    slow <= 1'b1;
    apb(1'b1, OFS_COUNT, 32'h3, 1'b0);
    base = go_cnt;
    start(SRC_IMMEDIATE, 1'b0);
    repeat (60) @(posedge clk);
    chk(go_cnt - base, 3);
    rd(OFS_DONE_CNT, 32'h3FFF, 32'h3);
    slow <= 1'b0;
    apb(1'b1, OFS_COUNT, 32'h0, 1'b0);
    base = go_cnt;
    start(SRC_IMMEDIATE, 1'b0);
    repeat (100) @(posedge clk);
    chk(go_cnt - base > 10, 1);
    apb(1'b1, OFS_CTRL, 32'h200, 1'b0);
    rd(OFS_STATUS, 32'h3, 32'h0);
    apb(1'b1, OFS_COUNT, 32'h2, 1'b0);
    base = go_cnt;
    start(SRC_EXTERNAL, 1'b1);
    repeat (20) @(posedge clk);
    chk(go_cnt - base, 1);
    rd(OFS_STATUS, 32'h20, 32'h20);
    fire(2);
    chk(go_cnt - base, 2);
    base = go_cnt;
    start(SRC_MULTI, 1'b0);
    repeat (20) @(posedge clk);
    chk(go_cnt - base, 0);
    conclude();
  end
endmodule
bind arm_layer_ctl arm_ctl_checker CHK (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SCAN_GO(SCAN_GO), .TBUS_OUT(TBUS_OUT), .TBUS_OE(TBUS_OE));
`default_nettype wire
